// [crw_ctrl.sv]
// Clock controller with time base, clock-out, beeper and watchdog.
`default_nettype none
module crw_ctrl
  import crw_pkg::*;
#(
  parameter int unsigned WDG_TICK = WDG_TICK_CYC,
  parameter int unsigned TB_P0 = TB_PER_0,
  parameter int unsigned TB_P1 = TB_PER_1,
  parameter int unsigned TB_P2 = TB_PER_2,
  parameter int unsigned TB_P3 = TB_PER_3
) (
  // Clock and reset.
  input wire logic aclk,
  input wire logic aresetn,
  // Register bus, write side.
  input wire logic [ADDR_W-1:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  // Register bus, read side.
  input wire logic [ADDR_W-1:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  // CPU and system events.
  input wire logic halt_req,
  input wire logic ext_irq,
  input wire logic cpu_irq_mask,
  // Option straps.
  input wire logic opt_hw_watchdog,
  input wire logic halt_reset_option,
  input wire logic opt_long_resume,
  // Clock, reset and wake outputs.
  output logic cpu_clk_en,
  output logic sys_reset_req,
  output logic rtc_irq,
  output logic wake,
  output logic active_halt,
  output logic full_halt,
  // Pins.
  output logic clk_out,
  output logic clk_out_oe,
  output logic beep_out,
  output logic beep_oe
);
  crw_pwr_t pwr_q;
  logic aw_have_q, w_have_q, bvalid_q, rvalid_q, wlane_q;
  logic [ADDR_W-1:0] awaddr_q;
  logic [7:0] wbyte_q, rbyte_q;
  logic [1:0] bresp_q, rresp_q;
  logic watchdog_activate_q, t6_prev_q;
  logic [6:0] wdg_cnt_q;
  logic [13:0] wdg_pre_q;
  logic [12:0] resume_q;
  logic resume_arm_q;
  logic clock_out_select_q, slow_select_q;
  logic timebase_irq_enable_q, timebase_flag_q;
  logic [1:0] slow_divider_select_q, timebase_select_q, tb_act_q;
  logic [1:0] beep_freq_select_q;
  logic [3:0] div_q;
  logic [17:0] rtc_cnt_q;
  logic cpu_clk_en_q, sys_reset_req_q, rtc_irq_q, wake_q;
  logic clk_out_q, clk_out_oe_q;

  function automatic logic [1:0] reg_sel(input logic [ADDR_W-1:0] a);
    if (a == ADDR_WDG_CTRL) begin
      return SEL_WDG;
    end else if (a == ADDR_CLK_CTRL) begin
      return SEL_CLK;
    end else if (a == ADDR_BEEP_CTRL) begin
      return SEL_BEEP;
    end else begin
      return SEL_NONE;
    end
  endfunction : reg_sel

  function automatic logic [17:0] tb_last(input logic [1:0] s);
    case (s)
      2'h0: return 18'(TB_P0 - 1);
      2'h1: return 18'(TB_P1 - 1);
      2'h2: return 18'(TB_P2 - 1);
      default: return 18'(TB_P3 - 1);
    endcase
  endfunction : tb_last

  // Bus writes land only while running, since halted registers are frozen.
  wire do_write = aw_have_q && w_have_q && !bvalid_q;
  wire wr_ok = do_write && wlane_q && pwr_q == PWR_RUN;
  wire wr_wdg = wr_ok && reg_sel(awaddr_q) == SEL_WDG;
  wire wr_clk = wr_ok && reg_sel(awaddr_q) == SEL_CLK;
  wire wr_beep = wr_ok && reg_sel(awaddr_q) == SEL_BEEP;
  wire rd_take = arvalid && arready;
  wire rd_clk = rd_take && reg_sel(araddr) == SEL_CLK;

  wire run_st = pwr_q == PWR_RUN;
  wire halt_exec = halt_req && run_st;
  wire halt_rst = halt_exec && !timebase_irq_enable_q && halt_reset_option;
  wire halt_enter = halt_exec && !timebase_irq_enable_q && !halt_reset_option;
  wire halt_exit = pwr_q == PWR_HALT && ext_irq;
  wire wdg_on = watchdog_activate_q || opt_hw_watchdog;
  wire wdg_run = run_st && resume_q == 13'h0000 && !resume_arm_q;
  wire wdg_tick = wdg_run && wdg_pre_q == 14'(WDG_TICK - 1);
  wire wdg_fire = wdg_on && t6_prev_q && !wdg_cnt_q[WDG_TOP_BIT]
                  && pwr_q != PWR_HALT;
  wire rtc_run = pwr_q != PWR_HALT;
  wire tb_event = rtc_run && rtc_cnt_q == tb_last(tb_act_q);
  wire [3:0] div_last = slow_select_q ?
                        4'((32'd2 << slow_divider_select_q) - 32'd1) : 4'h0;

  // Write channel: address and data are taken in either order.
  assign awready = !aw_have_q && !bvalid_q;
  assign wready = !w_have_q && !bvalid_q;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_q <= 1'b0;
      w_have_q <= 1'b0;
      bvalid_q <= 1'b0;
      bresp_q <= RESP_OKAY;
      awaddr_q <= '0;
      wbyte_q <= 8'h00;
      wlane_q <= 1'b0;
    end else begin
      if (awvalid && awready) begin
        aw_have_q <= 1'b1;
        awaddr_q <= awaddr;
      end
      if (wvalid && wready) begin
        w_have_q <= 1'b1;
        wbyte_q <= wdata[7:0];
        wlane_q <= wstrb[0];
      end
      if (do_write) begin
        aw_have_q <= 1'b0;
        w_have_q <= 1'b0;
        bvalid_q <= 1'b1;
        bresp_q <= reg_sel(awaddr_q) == SEL_NONE ? RESP_SLVERR : RESP_OKAY;
      end else if (bvalid_q && bready) begin
        bvalid_q <= 1'b0;
      end
    end
  end

  // Read channel; the answer comes one cycle after the address is taken.
  assign arready = !rvalid_q;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_q <= 1'b0;
      rresp_q <= RESP_OKAY;
      rbyte_q <= 8'h00;
    end else if (rd_take) begin
      rvalid_q <= 1'b1;
      rresp_q <= RESP_OKAY;
      if (reg_sel(araddr) == SEL_WDG) begin
        rbyte_q <= {watchdog_activate_q, wdg_cnt_q};
      end else if (reg_sel(araddr) == SEL_CLK) begin
        rbyte_q <= {clock_out_select_q, slow_divider_select_q,
                    slow_select_q, timebase_select_q,
                    timebase_irq_enable_q, timebase_flag_q};
      end else if (reg_sel(araddr) == SEL_BEEP) begin
        rbyte_q <= {6'h00, beep_freq_select_q};
      end else begin
        rbyte_q <= 8'h00;
        rresp_q <= RESP_SLVERR;
      end
    end else if (rvalid_q && rready) begin
      rvalid_q <= 1'b0;
    end
  end

  // Power state: halt, active halt and their exits.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pwr_q <= PWR_RUN;
    end else begin
      case (pwr_q)
        PWR_RUN: begin
          if (halt_exec && timebase_irq_enable_q) begin
            pwr_q <= PWR_AHALT;
          end else if (halt_enter) begin
            pwr_q <= PWR_HALT;
          end
        end
        PWR_AHALT: begin
          if (ext_irq || tb_event) begin
            pwr_q <= PWR_RUN;
          end
        end
        PWR_HALT: begin
          if (ext_irq) begin
            pwr_q <= PWR_RUN;
          end
        end
        default: pwr_q <= PWR_RUN;
      endcase
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wake_q <= 1'b0;
    end else begin
      wake_q <= (pwr_q == PWR_AHALT && (ext_irq || tb_event)) || halt_exit;
    end
  end

  // Watchdog register; the activate bit can only be set here.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      watchdog_activate_q <= WDG_CTRL_RST[WDG_ACT_BIT];
      wdg_cnt_q <= WDG_CTRL_RST[6:0];
    end else if (wr_wdg) begin
      watchdog_activate_q <= watchdog_activate_q
                             | wbyte_q[WDG_ACT_BIT];
      wdg_cnt_q <= wbyte_q[6:0];
    end else if (wdg_tick || halt_enter) begin
      wdg_cnt_q <= wdg_cnt_q - 7'h01;
    end
  end

  // Prescaler phase is unknown to software, so timeouts vary by one tick.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wdg_pre_q <= 14'h0000;
      t6_prev_q <= WDG_CTRL_RST[WDG_TOP_BIT];
    end else begin
      t6_prev_q <= wdg_cnt_q[WDG_TOP_BIT];
      if (wdg_tick) begin
        wdg_pre_q <= 14'h0000;
      end else if (wdg_run) begin
        wdg_pre_q <= wdg_pre_q + 14'h0001;
      end
    end
  end

  // Restart delay after a reset or after leaving full halt.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      resume_q <= 13'h0000;
      resume_arm_q <= 1'b1;
    end else if (resume_arm_q || halt_exit) begin
      resume_arm_q <= 1'b0;
      resume_q <= opt_long_resume ? 13'(RESUME_LONG_CLK)
                                  : 13'(RESUME_SHORT_CLK);
    end else if (resume_q != 13'h0000 && cpu_clk_en_q) begin
      resume_q <= resume_q - 13'h0001;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sys_reset_req_q <= 1'b0;
    end else begin
      sys_reset_req_q <= wdg_fire || halt_rst;
    end
  end

  // Clock control and status register.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      clock_out_select_q <= CLK_CTRL_RST[CLK_OUT_BIT];
      slow_divider_select_q <= CLK_CTRL_RST[CLK_DIV_LSB +: 2];
      slow_select_q <= CLK_CTRL_RST[CLK_SLOW_BIT];
      timebase_select_q <= CLK_CTRL_RST[CLK_TB_LSB +: 2];
      timebase_irq_enable_q <= CLK_CTRL_RST[CLK_IE_BIT];
    end else if (wr_clk) begin
      clock_out_select_q <= wbyte_q[CLK_OUT_BIT];
      slow_divider_select_q <= wbyte_q[CLK_DIV_LSB +: 2];
      slow_select_q <= wbyte_q[CLK_SLOW_BIT];
      timebase_select_q <= wbyte_q[CLK_TB_LSB +: 2];
      timebase_irq_enable_q <= wbyte_q[CLK_IE_BIT];
    end
  end

  // A new overflow in the cycle of the status read keeps the flag set.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      timebase_flag_q <= CLK_CTRL_RST[CLK_FLAG_BIT];
    end else if (tb_event) begin
      timebase_flag_q <= 1'b1;
    end else if (rd_clk) begin
      timebase_flag_q <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rtc_irq_q <= 1'b0;
    end else begin
      rtc_irq_q <= timebase_flag_q && timebase_irq_enable_q
                   && !cpu_irq_mask;
    end
  end

  // Time-base counter; the new period is taken only at period end.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rtc_cnt_q <= 18'h0_0000;
      tb_act_q <= CLK_CTRL_RST[CLK_TB_LSB +: 2];
    end else if (tb_event) begin
      rtc_cnt_q <= 18'h0_0000;
      tb_act_q <= timebase_select_q;
    end else if (rtc_run) begin
      rtc_cnt_q <= rtc_cnt_q + 18'h0_0001;
    end
  end

  // CPU clock divider; the CPU clock stops in both halt states.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      div_q <= 4'h0;
      cpu_clk_en_q <= 1'b0;
    end else begin
      div_q <= div_q >= div_last ? 4'h0 : div_q + 4'h1;
      cpu_clk_en_q <= run_st && div_q >= div_last;
    end
  end

  // Clock-out shows the CPU rate halved, as a pin cannot follow aclk.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      clk_out_q <= 1'b0;
      clk_out_oe_q <= 1'b0;
    end else begin
      if (pwr_q == PWR_AHALT) begin
        clk_out_q <= 1'b0;
      end else if (cpu_clk_en_q) begin
        clk_out_q <= ~clk_out_q;
      end
      clk_out_oe_q <= clock_out_select_q && pwr_q != PWR_AHALT;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      beep_freq_select_q <= BEEP_CTRL_RST[BEEP_SEL_LSB +: 2];
    end else if (wr_beep) begin
      beep_freq_select_q <= wbyte_q[BEEP_SEL_LSB +: 2];
    end
  end

  crw_beep u_beep (
    .aclk(aclk),
    .aresetn(aresetn),
    .beep_freq_select(beep_freq_select_q),
    .run(rtc_run),
    .beep_out(beep_out),
    .beep_oe(beep_oe)
  );

  assign bvalid = bvalid_q;
  assign bresp = bresp_q;
  assign rvalid = rvalid_q;
  assign rresp = rresp_q;
  assign rdata = {24'h00_0000, rbyte_q};
  assign cpu_clk_en = cpu_clk_en_q;
  assign sys_reset_req = sys_reset_req_q;
  assign rtc_irq = rtc_irq_q;
  assign wake = wake_q;
  assign active_halt = pwr_q == PWR_AHALT;
  assign full_halt = pwr_q == PWR_HALT;
  assign clk_out = clk_out_q;
  assign clk_out_oe = clk_out_oe_q;

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  chk_wdg_tick_dec: assert property (
    wdg_tick && !wr_wdg |=> wdg_cnt_q == $past(wdg_cnt_q) - 7'h01)
    else $error("Watchdog count did not step down on a tick.");
  chk_wdg_roll_rst: assert property (
    wdg_on && $fell(wdg_cnt_q[WDG_TOP_BIT]) && pwr_q != PWR_HALT
    |=> sys_reset_req)
    else $error("Watchdog roll past 40h gave no reset.");
  chk_wdg_off_quiet: assert property (
    !wdg_on && !halt_rst |=> !sys_reset_req)
    else $error("Disabled watchdog raised a reset.");
  chk_activate_sticky: assert property (
    watchdog_activate_q |=> watchdog_activate_q)
    else $error("Watchdog activate bit cleared without reset.");
  chk_halt_enter: assert property (
    halt_enter && !wr_wdg
    |=> pwr_q == PWR_HALT && wdg_cnt_q == $past(wdg_cnt_q) - 7'h01)
    else $error("Halt entry missed state or single decrement.");
  chk_halt_frozen: assert property (
    pwr_q == PWR_HALT ##1 pwr_q == PWR_HALT
    |-> $stable(rtc_cnt_q) && $stable(wdg_cnt_q))
    else $error("Counters moved during full halt.");
  chk_resume_delay: assert property (
    halt_exit |=> !wdg_run [*8])
    else $error("Watchdog restarted without delay after halt.");
  chk_halt_reset: assert property (
    halt_rst |=> sys_reset_req && pwr_q == PWR_RUN)
    else $error("Halt with reset option gave no reset.");
  chk_ahalt_enter: assert property (
    halt_exec && timebase_irq_enable_q |=> pwr_q == PWR_AHALT
    ##1 $stable(wdg_cnt_q))
    else $error("Active halt not entered or watchdog ran.");
  chk_clkout_ahalt: assert property (
    pwr_q == PWR_AHALT |=> !clk_out_oe)
    else $error("Clock-out driven during active halt.");
  chk_tb_switch: assert property (
    !tb_event |=> $stable(tb_act_q))
    else $error("Time base changed mid period.");
  chk_flag_set: assert property (
    tb_event |=> timebase_flag_q)
    else $error("Overflow did not set the time-base flag.");
  chk_irq_gate: assert property (
    tb_event && timebase_irq_enable_q && !cpu_irq_mask && !wr_clk
    ##1 !cpu_irq_mask |=> rtc_irq)
    else $error("Enabled unmasked overflow gave no interrupt.");

  cov_halt_wake: cover property (pwr_q == PWR_HALT ##1 pwr_q == PWR_RUN);
  cov_ahalt_wake: cover property (pwr_q == PWR_AHALT && tb_event);
  cov_wdg_reset: cover property (wdg_fire);
  cov_slow_mode: cover property (slow_select_q && cpu_clk_en);
endmodule : crw_ctrl
`default_nettype wire

// [crw_pkg.sv]
// Shared register map, field positions, reset values and timing counts.
`default_nettype none
package crw_pkg;
  localparam int unsigned ADDR_W = 8;
  // Register indexes; the bus byte address is four times the index.
  localparam logic [7:0] IDX_WDG_CTRL = 8'h2A;
  localparam logic [7:0] IDX_CLK_CTRL = 8'h2C;
  localparam logic [7:0] IDX_BEEP_CTRL = 8'h2D;
  localparam logic [7:0] ADDR_WDG_CTRL = 8'(IDX_WDG_CTRL * 4);
  localparam logic [7:0] ADDR_CLK_CTRL = 8'(IDX_CLK_CTRL * 4);
  localparam logic [7:0] ADDR_BEEP_CTRL = 8'(IDX_BEEP_CTRL * 4);
  // Register select codes.
  localparam logic [1:0] SEL_NONE = 2'h0;
  localparam logic [1:0] SEL_WDG = 2'h1;
  localparam logic [1:0] SEL_CLK = 2'h2;
  localparam logic [1:0] SEL_BEEP = 2'h3;
  // Field positions.
  localparam int unsigned WDG_ACT_BIT = 7;
  localparam int unsigned WDG_TOP_BIT = 6;
  localparam int unsigned CLK_OUT_BIT = 7;
  localparam int unsigned CLK_DIV_LSB = 5;
  localparam int unsigned CLK_SLOW_BIT = 4;
  localparam int unsigned CLK_TB_LSB = 2;
  localparam int unsigned CLK_IE_BIT = 1;
  localparam int unsigned CLK_FLAG_BIT = 0;
  localparam int unsigned BEEP_SEL_LSB = 0;
  // Reset values.
  localparam logic [7:0] WDG_CTRL_RST = 8'h7F;
  localparam logic [7:0] CLK_CTRL_RST = 8'h00;
  localparam logic [7:0] BEEP_CTRL_RST = 8'h00;
  // Timing counts in oscillator-half cycles unless noted.
  localparam int unsigned WDG_TICK_CYC = 16384;
  localparam int unsigned TB_PER_0 = 16000;
  localparam int unsigned TB_PER_1 = 32000;
  localparam int unsigned TB_PER_2 = 80000;
  localparam int unsigned TB_PER_3 = 200000;
  localparam int unsigned BEEP_HALF_1 = 2000;
  localparam int unsigned BEEP_HALF_2 = 4000;
  localparam int unsigned BEEP_HALF_3 = 8000;
  // Watchdog restart delays, in CPU clocks.
  localparam int unsigned RESUME_SHORT_CLK = 256;
  localparam int unsigned RESUME_LONG_CLK = 4096;
  // Bus responses.
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // Power states, Gray coded only between run and active halt; run to full halt flips both bits.
  typedef enum logic [1:0] {
    PWR_RUN = 2'h0,
    PWR_AHALT = 2'h1,
    PWR_HALT = 2'h3
  } crw_pwr_t;
endpackage : crw_pkg
`default_nettype wire

// [crw_beep.sv]
// Beeper tone generator with three selectable half periods.
`default_nettype none
module crw_beep
  import crw_pkg::*;
#(
  parameter int unsigned HALF_1 = BEEP_HALF_1,
  parameter int unsigned HALF_2 = BEEP_HALF_2,
  parameter int unsigned HALF_3 = BEEP_HALF_3
) (
  // Clock and reset.
  input wire logic aclk,
  input wire logic aresetn,
  // Control.
  input wire logic [1:0] beep_freq_select,
  input wire logic run,
  // Pin.
  output logic beep_out,
  output logic beep_oe
);
  logic [13:0] cnt_q;
  logic tone_q;
  logic oe_q;
  logic [13:0] half_last;

  always_comb begin
    case (beep_freq_select)
      2'h1: half_last = 14'(HALF_1 - 1);
      2'h2: half_last = 14'(HALF_2 - 1);
      2'h3: half_last = 14'(HALF_3 - 1);
      default: half_last = 14'h0000;
    endcase
  end

  // Square wave toggles every half period, giving close to even duty.
  always_ff @(posedge aclk) begin
    if (!aresetn || beep_freq_select == 2'h0) begin
      cnt_q <= 14'h0000;
      tone_q <= 1'b0;
    end else if (run) begin
      if (cnt_q >= half_last) begin
        cnt_q <= 14'h0000;
        tone_q <= ~tone_q;
      end else begin
        cnt_q <= cnt_q + 14'h0001;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      oe_q <= 1'b0;
    end else begin
      oe_q <= beep_freq_select != 2'h0;
    end
  end

  assign beep_out = tone_q;
  assign beep_oe = oe_q;
endmodule : crw_beep
`default_nettype wire

// [clock_rtc_watchdog_ctrl_tb.sv]
// Self-checking testbench for the clock, time-base and watchdog controller.
`default_nettype none
module clock_rtc_watchdog_ctrl_tb_top
  import crw_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int PER[4] = '{20, 30, 40, 50};
  localparam int HV[4] = '{0, BEEP_HALF_1, BEEP_HALF_2, BEEP_HALF_3};
  logic aclk = 1'h0;
  logic aresetn, awvalid, wvalid, bready, arvalid, rready, halt_req;
  logic ext_irq, cpu_irq_mask, opt_hw_watchdog, halt_reset_option;
  logic opt_long_resume, awready, wready, bvalid, arready, rvalid;
  logic cpu_clk_en, sys_reset_req, rtc_irq, wake, active_halt, full_halt;
  logic clk_out, clk_out_oe, beep_out, beep_oe, hit;
  logic [7:0] awaddr, araddr;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, rs_q;
  logic [31:0] wdata, rdata, rd_q, cnt;
  int failures = 0;
  int n_checks = 0;
  time t0;
  always #5 aclk = ~aclk;
  crw_ctrl #(.WDG_TICK(16), .TB_P0(PER[0]), .TB_P1(PER[1]), .TB_P2(PER[2]),
    .TB_P3(PER[3])) u_crw_ctrl (
    .aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
    .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
    .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata),
    .rresp(rresp), .rvalid(rvalid), .rready(rready), .halt_req(halt_req),
    .ext_irq(ext_irq), .cpu_irq_mask(cpu_irq_mask),
    .opt_hw_watchdog(opt_hw_watchdog), .halt_reset_option(halt_reset_option),
    .opt_long_resume(opt_long_resume), .cpu_clk_en(cpu_clk_en),
    .sys_reset_req(sys_reset_req), .rtc_irq(rtc_irq), .wake(wake),
    .active_halt(active_halt), .full_halt(full_halt), .clk_out(clk_out),
    .clk_out_oe(clk_out_oe), .beep_out(beep_out), .beep_oe(beep_oe));
  task automatic end_of_test();
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : end_of_test
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_checks++;
    if (g !== e) begin
      failures++;
      $display("ERROR %0t got %h exp %h", $time, g, e);
    end
  endtask : chk
  task automatic rst();
    @(posedge aclk);
    aresetn <= 1'h0;
    repeat (5) @(posedge aclk);
    aresetn <= 1'h1;
  endtask : rst
  // Readies are sampled at the falling edge, so the handshake seen is the
  // one that the next rising edge really completes.
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic ta, tw;
    @(posedge aclk);
    awaddr <= a;
    wdata <= {24'h00_0000, d};
    wstrb <= 4'hF;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    for (int i = 0; i < 64; i++) begin
      @(negedge aclk);
      ta = awvalid && awready;
      tw = wvalid && wready;
      hit = bvalid;
      rs_q = bresp;
      @(posedge aclk);
      if (ta) awvalid <= 1'h0;
      if (tw) wvalid <= 1'h0;
      if (hit) begin
        bready <= 1'h0;
        return;
      end
    end
    chk(1'h0, 1'h1);
    end_of_test();
  endtask : wr
  task automatic rd(input logic [7:0] a);
    logic ta;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'h1;
    rready <= 1'h1;
    for (int i = 0; i < 64; i++) begin
      @(negedge aclk);
      ta = arvalid && arready;
      hit = rvalid;
      rd_q = rdata;
      rs_q = rresp;
      @(posedge aclk);
      if (ta) arvalid <= 1'h0;
      if (hit) begin
        rready <= 1'h0;
        return;
      end
    end
    chk(1'h0, 1'h1);
    end_of_test();
  endtask : rd
  function automatic logic pick(input int s);
    case (s)
      0: return rtc_irq;
      1: return sys_reset_req;
      2: return active_halt;
      3: return full_halt;
      4: return wake;
      5: return !active_halt;
      default: return !full_halt;
    endcase
  endfunction : pick
  task automatic wt(input int s, input int n, input logic e);
    hit = 1'h0;
    for (int i = 0; i < n && !hit; i++) begin
      @(negedge aclk);
      hit = pick(s);
    end
    chk(hit, e);
    if (e && hit !== e) end_of_test();
  endtask : wt
  task automatic pulse(input logic h);
    @(posedge aclk);
    if (h) halt_req <= 1'h1;
    else ext_irq <= 1'h1;
    @(posedge aclk);
    halt_req <= 1'h0;
    ext_irq <= 1'h0;
  endtask : pulse
  initial begin
    {aresetn, awaddr, araddr, awvalid, wvalid, bready, arvalid, rready,
      wdata, wstrb, halt_req, ext_irq, cpu_irq_mask, opt_hw_watchdog,
      halt_reset_option, opt_long_resume} = '0;
    rst();
    rd(ADDR_WDG_CTRL);
    chk(rd_q, 32'h0000_007F);
    rd(8'h04);
    chk(32'(rs_q), 32'(RESP_SLVERR));
    wr(8'h04, 8'h55);
    chk(32'(rs_q), 32'(RESP_SLVERR));
    $display("done: reset");
    for (int d = 0; d < 5; d++) begin
      wr(ADDR_CLK_CTRL, d < 4 ? 8'(8'h10 | (d << 5)) : 8'h00);
      cnt = 0;
      repeat (64) @(negedge aclk) cnt += cpu_clk_en;
      chk(cnt, d < 4 ? 32'(64 >> (d + 1)) : 32'd64);
    end
    $display("done: cpu clock");
    wr(ADDR_CLK_CTRL, 8'h82);
    @(negedge aclk);
    chk(clk_out_oe, 1'h1);
    chk(32'(rs_q), 32'(RESP_OKAY));
    hit = clk_out;
    @(negedge aclk);
    chk(clk_out ^ hit, 1'h1);
    pulse(1'h1);
    wt(2, 4, 1'h1);
    @(negedge aclk);
    chk(clk_out_oe, 1'h0);
    chk(clk_out, 1'h0);
    wt(5, 80, 1'h1);
    $display("done: active halt");
    wr(ADDR_CLK_CTRL, 8'h00);
    wr(ADDR_WDG_CTRL, 8'h7F);
    pulse(1'h1);
    wt(3, 4, 1'h1);
    wt(6, 200, 1'h0);
    pulse(1'h0);
    // The wake pulse stands for one cycle only, so it is looked at first.
    wt(4, 4, 1'h1);
    wt(6, 4, 1'h1);
    $display("done: full halt");
    // Three waits: the first finds the flag still set, the second may still end a period begun before the change.
    for (int c = 0; c < 4; c++) begin
      wr(ADDR_CLK_CTRL, 8'(c * 4 + 2));
      wt(0, 120, 1'h1);
      rd(ADDR_CLK_CTRL);
      wt(0, 120, 1'h1);
      t0 = $time;
      rd(ADDR_CLK_CTRL);
      chk(rd_q, 32'(c * 4 + 3));
      wt(0, 120, 1'h1);
      chk(32'($time - t0), 32'(PER[c] * 10));
    end
    @(posedge aclk);
    cpu_irq_mask <= 1'h1;
    @(posedge aclk);
    wt(0, 120, 1'h0);
    $display("done: time base");
    wr(ADDR_CLK_CTRL, 8'h00);
    halt_reset_option <= 1'h1;
    pulse(1'h1);
    wt(1, 4, 1'h1);
    halt_reset_option <= 1'h0;
    rst();
    wr(ADDR_WDG_CTRL, 8'h41);
    wt(1, 600, 1'h0);
    wr(ADDR_WDG_CTRL, 8'hC1);
    wt(1, 16, 1'h0);
    wt(1, 20, 1'h1);
    rst();
    rd(ADDR_WDG_CTRL);
    chk(rd_q[7], 1'h0);
    opt_hw_watchdog <= 1'h1;
    wr(ADDR_WDG_CTRL, 8'h41);
    wt(1, 400, 1'h1);
    opt_long_resume <= 1'h1;
    rst();
    wr(ADDR_WDG_CTRL, 8'h41);
    wt(1, 3000, 1'h0);
    wt(1, 1400, 1'h1);
    opt_long_resume <= 1'h0;
    opt_hw_watchdog <= 1'h0;
    rst();
    $display("done: watchdog");
    for (int b = 0; b < 4; b++) begin
      wr(ADDR_BEEP_CTRL, 8'(b));
      repeat (8000) @(negedge aclk);
      chk(beep_oe, b != 0);
      cnt = 0;
      hit = beep_out;
      repeat (8000) begin
        @(negedge aclk);
        cnt += 32'(beep_out ^ hit);
        hit = beep_out;
      end
      chk(cnt, HV[b] == 0 ? 32'd0 : 32'(8000 / HV[b]));
    end
    $display("done: beeper");
    end_of_test();
  end
endmodule : clock_rtc_watchdog_ctrl_tb_top
`default_nettype wire
